// *** dv/card_specific_data_regs_tb.sv ***
// Self-checking bench: host and card joined on one link, a second card facing a faulty host.
// Assumes the package and both ends from src/; the bench itself plays the faulty host.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module card_specific_data_regs_tb;
  import cdr_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic [5:0] req_idx = 6'h00;
  logic [31:0] req_arg = 32'h0;
  logic [127:0] req_data = 128'h0;
  logic req_ready, resp_valid, resp_timeout, init_done, single_erase_ok, ready, selected, ready_b;
  logic copy_flag, perm_protect, temp_protect;
  logic [127:0] resp_data;
  logic [15:0] h_addr, c_addr, relative_card_address;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  cdr_link_if i_cdr_link_if ();
  cdr_link_if i_cdr_link_if_b ();
  cdr_host #(.SPI_MODE(1'b0)) i_cdr_host (.clk(clk), .rst_b(rst_b), .lnk(i_cdr_link_if.host),
    .req_valid(req_valid), .req_idx(req_idx), .req_arg(req_arg), .req_data(req_data), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_timeout(resp_timeout), .resp_data(resp_data), .init_done(init_done),
    .card_address(h_addr), .single_erase_ok(single_erase_ok));
  // Non-default options so the image shows each option bit but the size's top two, which read zero
  cdr_card #(.RATE_HIGH(1'b1), .CLASS_X(1'b1), .DRIVER_STAGE(1'b1), .DEVICE_SIZE(22'h3C1234)) i_cdr_card (
    .clk(clk), .rst_b(rst_b), .lnk(i_cdr_link_if.dev), .ready(ready), .selected(selected),
    .card_address(c_addr), .copy_flag(copy_flag), .perm_protect(perm_protect), .temp_protect(temp_protect));
  cdr_card i_cdr_card_b (.clk(clk), .rst_b(rst_b), .lnk(i_cdr_link_if_b.dev), .ready(ready_b), .selected(),
    .card_address(), .copy_flag(), .perm_protect(), .temp_protect());
  cdr_link_monitor i_cdr_link_monitor (.clk(clk), .rst_b(rst_b), .lclk(i_cdr_link_if.lclk),
    .cs_hi(i_cdr_link_if.cs_hi), .cmd_h_o(i_cdr_link_if.cmd_h_o), .cmd_h_oe(i_cdr_link_if.cmd_h_oe),
    .cmd_d_o(i_cdr_link_if.cmd_d_o), .cmd_d_oe(i_cdr_link_if.cmd_d_oe), .cmd_line(i_cdr_link_if.cmd_line));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [127:0] img(input logic c, input logic p, input logic t, input logic [6:0] crc);
    img = {2'h1, 6'h00, 8'h0E, 8'h00, 8'h5A, 12'h7B5, 4'h9, 3'h0, 1'h1, 6'h00, 22'h0C1234, 2'h1, 7'h7F,
      7'h00, 1'h0, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00, 1'h0, c, p, t, 4'h0, crc, 1'h1};
  endfunction

  task automatic req(input logic [5:0] idx, input logic [31:0] arg, input logic [127:0] data);
    int n;
    for (n = 0; n < 2000 && req_ready !== 1'b1; n++) @(posedge clk);
    if (n >= 2000) failures++;
    req_valid <= 1'b1;
    req_idx <= idx;
    req_arg <= arg;
    req_data <= data;
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 3000 && resp_valid !== 1'b1; n++) @(posedge clk);
    if (n >= 3000) failures++;
  endtask

  task automatic prog(input logic [127:0] d, input logic [7:0] st);
    req(CMD_PROGRAM_SPECIFICS, 32'h0, d);
    `CHK(resp_data[7:0], st)
  endtask

  task automatic wait_init;
    int n;
    for (n = 0; n < 2000 && init_done !== 1'b1; n++) @(posedge clk);
    if (n >= 2000) failures++;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // power-up state
  task automatic t_power_up;
    repeat (100) @(posedge clk);
    `CHK(ready, 1'b0)
    `CHK(c_addr, 16'h0000)
    wait_init();
    `CHK(ready, 1'b1)
    `CHK(c_addr, 16'h0000)
  endtask

  task automatic t_bad_preamble;
    int n;
    for (n = 0; n < 120; n++) begin
      i_cdr_link_if_b.cmd_h_o <= (n != 40);
      repeat (4) @(posedge clk);
      i_cdr_link_if_b.lclk <= 1'b1;
      repeat (4) @(posedge clk);
      i_cdr_link_if_b.lclk <= 1'b0;
      if (n == 100) `CHK(ready_b, 1'b0)
    end
    repeat (8) @(posedge clk);
    `CHK(ready_b, 1'b1)
  endtask

  task automatic t_publish;
    req(CMD_PUBLISH_ADDR, 32'h0, 128'h0);
    relative_card_address = resp_data[15:0];
    `CHK(resp_timeout, 1'b0)
    `CHK(relative_card_address != 16'h0000, 1'b1)
    `CHK(c_addr, relative_card_address)
    `CHK(h_addr, relative_card_address)
  endtask

  task automatic t_read_fields;
    req(CMD_SEND_SPECIFICS, 32'h0, 128'h0);
    `CHK(resp_data[119:104], 16'h0E00)
    `CHK(resp_data[103:96], 8'h5A)
    `CHK(resp_data[95:84], 12'h7B5)
    `CHK(resp_data[83:79], 5'h12)
    `CHK(resp_data[78:77], 2'h0)
    `CHK(resp_data[46:39], 8'hFF)
    `CHK(resp_data[38:31], 8'h00)
    `CHK(resp_data[25:21], 5'h12)
    `CHK(resp_data[69:68], 2'h0)
    `CHK(resp_data, img(1'b0, 1'b0, 1'b0, 7'h00))
    `CHK(single_erase_ok, 1'b1)
  endtask

  task automatic t_program;
    req(CMD_SELECT, {relative_card_address, 16'h0000}, 128'h0);
    `CHK(selected, 1'b1)
    prog(img(1'b1, 1'b0, 1'b1, 7'h55), 8'h01);
    `CHK({copy_flag, perm_protect, temp_protect}, 3'b101)
    prog(img(1'b1, 1'b0, 1'b1, 7'h55) ^ (128'h1 << 46), 8'h03);
    prog(img(1'b0, 1'b1, 1'b1, 7'h55), 8'h05);
    `CHK({copy_flag, perm_protect, temp_protect}, 3'b101)
    prog(img(1'b1, 1'b1, 1'b0, 7'h2A), 8'h01);
    `CHK({copy_flag, perm_protect, temp_protect}, 3'b110)
  endtask

  task automatic t_deselect;
    req(CMD_SELECT, 32'h0, 128'h0);
    `CHK(selected, 1'b0)
    req(CMD_PROGRAM_SPECIFICS, 32'h0, img(1'b1, 1'b1, 1'b1, 7'h00));
    `CHK(resp_timeout, 1'b1)
    req(CMD_SEND_SPECIFICS, 32'h0, 128'h0);
    `CHK(resp_data, img(1'b1, 1'b1, 1'b0, 7'h2A))
  endtask

  task automatic t_reset_again;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(c_addr, 16'h0000)
    rst_b <= 1'b1;
    wait_init();
    `CHK(ready, 1'b1)
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic close_out;
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Faulty host side: clock stands still until the fault scenario runs
  initial begin
    i_cdr_link_if_b.lclk = 1'b0;
    i_cdr_link_if_b.cs_hi = 1'b1;
    i_cdr_link_if_b.cmd_h_o = 1'b1;
    i_cdr_link_if_b.cmd_h_oe = 1'b1;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_power_up();
    t_bad_preamble();
    t_publish();
    t_read_fields();
    t_program();
    t_deselect();
    t_reset_again();
    close_out();
  end
endmodule // card_specific_data_regs_tb

// *** dv/cdr_link_monitor.sv ***
// Wire-level checks on the link that joins the host end and the card end.
// Assumes both ends run on clk and share rst_b; sees only link signals.
`timescale 1ns/1ns
module cdr_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link signals
  input wire logic lclk,
  input wire logic cs_hi,
  input wire logic cmd_h_o,
  input wire logic cmd_h_oe,
  input wire logic cmd_d_o,
  input wire logic cmd_d_oe,
  input wire logic cmd_line
);
  // ****************************************
  // Preamble tracking
  // ****************************************
  logic lclk_q;
  logic alive_q;
  logic [7:0] rise_q;
  logic in_pre;
  logic [10:0] oe_run_q;

  // Saturates so a long run never wraps back into the preamble window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lclk_q <= 1'b0;
      alive_q <= 1'b0;
      rise_q <= 8'h00;
      oe_run_q <= 11'h000;
    end else begin
      lclk_q <= lclk;
      alive_q <= 1'b1;
      if (lclk && !lclk_q && rise_q != 8'hFF) begin
        rise_q <= rise_q + 8'h01;
      end
      // Card drive run length; saturates so a stuck driver keeps failing
      if (!cmd_d_oe) begin
        oe_run_q <= 11'h000;
      end else if (oe_run_q != 11'h7FF) begin
        oe_run_q <= oe_run_q + 11'h001;
      end
    end
  end
  assign in_pre = alive_q && (rise_q < 8'h4A);

  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_lclk_high;
    lclk [*4];
  endsequence
  sequence s_lclk_low;
    !lclk [*4];
  endsequence
  sequence s_card_quiet;
    !cmd_d_oe [*8];
  endsequence

  AST_PRE_CMD_HIGH: assert property (in_pre |-> cmd_line && cmd_h_oe)
    else $error("command line not held high in preamble");
  AST_PRE_CS_HIGH: assert property (in_pre |-> cs_hi)
    else $error("chip select low in preamble");
  AST_PRE_CARD_QUIET: assert property (in_pre |-> !cmd_d_oe)
    else $error("card drove during preamble");
  AST_LCLK_SHAPE: assert property ($rose(lclk) |-> s_lclk_high ##1 s_lclk_low)
    else $error("link clock phase length wrong");
  AST_NO_CLASH: assert property (!(cmd_h_oe && cmd_d_oe))
    else $error("both ends drive the command line");
  AST_HOST_CHANGE_LOW: assert property (cmd_h_oe && $past(cmd_h_oe) && $changed(cmd_h_o) |-> !lclk)
    else $error("host changed command bit while link clock high");
  AST_RESP_START: assert property ($rose(cmd_d_oe) |-> !cmd_d_o)
    else $error("answer without start bit");
  AST_RESP_END: assert property ($fell(cmd_d_oe) |-> $past(cmd_d_o))
    else $error("answer without end bit");
  AST_RESP_SPAN: assert property ($rose(cmd_d_oe) |-> cmd_d_oe [*8])
    else $error("answer shorter than one link bit");
  // Longest answer is start, 128 bits and end: about 1040 cycles
  AST_RESP_LIMIT: assert property (cmd_d_oe |-> oe_run_q < 11'h44C)
    else $error("answer length out of range");
  AST_ANSWER_GAP: assert property ($fell(cmd_h_oe) |-> s_card_quiet)
    else $error("card answered without turnaround gap");
endmodule // cdr_link_monitor

// *** src/cdr_card.sv ***
// Card end: card-specific data and relative address registers behind the command line.
// Assumes the link clock and command line arrive asynchronously; both are double-synchronised.
//
// How it works
// RULE1: 128-bit register, writable cells via program command
// RULE2: Access time fields read 0Eh and 00h
// RULE3: Transfer rate field reads 32h or 5Ah
// RULE4: Command class set reads 01x110110101b
// RULE5: Read length code 9, no partial reads
// RULE6: Both misalignment bits read zero
// RULE7: Single erase bit 1, sector size 7Fh
// RULE8: Protect group enable 0, size zero
// RULE9: Write length code 9, no partial writes
// RULE10: Copy and permanent protect are one-time
// RULE11: Temporary protect and checksum freely rewritable
// RULE12: Host checks erase bit before erasing
// RULE13: Address register 16 bits, zero after reset
// RULE14: Card publishes address; host uses it
// RULE15: Zero never assigned; select zero deselects
// RULE16: Host gives 74 clocks, command high
// RULE17: Chip select high during the preamble
// RULE18: Version 01b, bit 0 one, reserved zero
// RULE19: Read-only cells never changed by programming
// RULE20: Size field top two bits zero
`timescale 1ns/1ns
module cdr_card #(
  parameter bit RATE_HIGH = 1'b0,
  parameter bit CLASS_X = 1'b0,
  parameter bit DRIVER_STAGE = 1'b0,
  parameter logic [21:0] DEVICE_SIZE = 22'h003B37
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  cdr_link_if.dev lnk,
  // Card state
  output logic ready,
  output logic selected,
  output logic [15:0] card_address,
  output logic copy_flag,
  output logic perm_protect,
  output logic temp_protect
);
  import cdr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    D_PRE, D_IDLE, D_RX, D_DEC, D_RXD_WAIT, D_RXD, D_RXD_END, D_PROG, D_GAP, D_TXS, D_TXB, D_TXE, D_REL
  } cdr_dst_t;

  typedef struct packed {
    cdr_dst_t st;
    logic lk_m;
    logic lk_s;
    logic lk_p;
    logic cm_m;
    logic cm_s;
    logic [7:0] cnt;
    logic [1:0] gap;
    logic [46:0] sh;
    logic [127:0] buf_r;
    logic [15:0] addr;
    logic [15:0] ctr;
    logic sel;
    logic copy;
    logic perm;
    logic temp;
    logic [6:0] crc;
    logic cmd_o;
    logic cmd_oe;
    logic rdy;
  } cdr_dev_t;

  cdr_dev_t q, d;
  logic rise;
  logic [5:0] idx;
  logic [15:0] arg_addr;
  logic [127:0] img;
  logic ro_bad;
  logic otp_bad;

  // ****************************************
  // Register image
  // ****************************************
  function automatic logic [127:0] card_image(input logic cp, input logic pm, input logic tp,
                                               input logic [6:0] crc);
    logic [127:0] r;
    r = '0;
    // RULE18: fixed version and trailing one
    r[P_VERSION +: 2] = V_VERSION;
    r[0] = 1'b1;
    // RULE2: access time constants
    r[P_ACCESS_TIME +: 8] = V_ACCESS_TIME;
    r[P_ACCESS_CLOCKS +: 8] = V_ACCESS_CLOCKS;
    // RULE3: one of two rates
    r[P_RATE +: 8] = RATE_HIGH ? V_RATE_HIGH : V_RATE_LOW;
    // RULE4: class set with variable bit
    r[P_CLASSES +: 12] = {V_CLASSES_HI, CLASS_X, V_CLASSES_LO};
    // RULE5: read block limits
    r[P_RD_LEN +: 4] = V_BLOCK_LEN;
    r[P_RD_PARTIAL] = 1'b0;
    // RULE6: no misaligned blocks
    r[P_WR_MISALIGN] = 1'b0;
    r[P_RD_MISALIGN] = 1'b0;
    r[P_DRIVER_STAGE] = DRIVER_STAGE;
    // RULE20: size with top bits forced clear
    r[P_SIZE +: 22] = {2'h0, DEVICE_SIZE[19:0]};
    // RULE7: erase fields
    r[P_ERASE_SINGLE] = 1'b1;
    r[P_SECTOR +: 7] = V_SECTOR;
    // RULE8: no protect groups
    r[P_GRP_SIZE +: 7] = V_GRP_SIZE;
    r[P_GRP_EN] = 1'b0;
    r[P_SPEED_FACTOR +: 3] = V_SPEED_FACTOR;
    // RULE9: write block limits
    r[P_WR_LEN +: 4] = V_BLOCK_LEN;
    r[P_WR_PARTIAL] = 1'b0;
    r[P_COPY] = cp;
    r[P_PERM] = pm;
    r[P_TEMP] = tp;
    r[P_CRC +: 7] = crc;
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    rise = q.lk_s & ~q.lk_p;
    idx = q.sh[45:40];
    arg_addr = q.sh[39:24];
    img = card_image(q.copy, q.perm, q.temp, q.crc);
    // RULE19: any read-only difference rejects the write
    ro_bad = |((q.buf_r ^ img) & ~WRITABLE_MASK);
    // RULE10: a programmed one may not be cleared
    otp_bad = (q.copy & ~q.buf_r[P_COPY]) | (q.perm & ~q.buf_r[P_PERM]);
    d.lk_m = lnk.lclk;
    d.lk_s = q.lk_m;
    d.lk_p = q.lk_s;
    d.cm_m = lnk.cmd_line;
    d.cm_s = q.cm_m;
    // RULE15: address source skips zero
    d.ctr = (q.ctr == 16'hFFFF) ? 16'h0001 : q.ctr + 16'h0001;
    unique case (q.st)
      D_PRE: begin
        // RULE16: count link clocks with the line high
        if (rise) begin
          if (!q.cm_s) begin
            d.cnt = '0;
          end else if (q.cnt == PRE_CLOCKS - 8'h01) begin
            d.st = D_IDLE;
            d.rdy = 1'b1;
          end else begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
      D_IDLE: begin
        if (rise && !q.cm_s) begin
          d.st = D_RX;
          d.cnt = FRAME_BITS - 8'h01;
        end
      end
      D_RX: begin
        if (rise) begin
          d.sh = {q.sh[45:0], q.cm_s};
          d.cnt = q.cnt - 8'h01;
          if (q.cnt == 8'h01) begin
            d.st = D_DEC;
          end
        end
      end
      D_DEC: begin
        d.st = D_IDLE;
        d.gap = '0;
        if (q.sh[46] && q.sh[0]) begin
          if (idx == CMD_PUBLISH_ADDR) begin
            // RULE14: publish a fresh nonzero address
            d.addr = q.ctr;
            d.buf_r = {q.ctr, 112'h0};
            d.cnt = LEN_ADDR;
            d.st = D_GAP;
          end else if (idx == CMD_SELECT) begin
            // RULE15: zero or another address deselects
            d.sel = (arg_addr == q.addr) && (q.addr != 16'h0000);
            d.buf_r = {7'h00, d.sel, 120'h0};
            d.cnt = LEN_STATUS;
            d.st = D_GAP;
          end else if (idx == CMD_SEND_SPECIFICS && arg_addr == q.addr && q.addr != 16'h0000) begin
            // RULE14: addressed read only on a match
            d.buf_r = img;
            d.cnt = LEN_SPECIFICS;
            d.st = D_GAP;
          end else if (idx == CMD_PROGRAM_SPECIFICS && q.sel) begin
            // RULE1: program command takes a data frame
            d.st = D_RXD_WAIT;
          end
        end
      end
      D_RXD_WAIT: begin
        if (rise && !q.cm_s) begin
          d.st = D_RXD;
          d.cnt = DATA_BITS;
        end
      end
      D_RXD: begin
        if (rise) begin
          d.buf_r = {q.buf_r[126:0], q.cm_s};
          d.cnt = q.cnt - 8'h01;
          if (q.cnt == 8'h01) begin
            d.st = D_RXD_END;
          end
        end
      end
      D_RXD_END: begin
        if (rise) begin
          d.st = q.cm_s ? D_PROG : D_IDLE;
        end
      end
      D_PROG: begin
        if (!ro_bad && !otp_bad) begin
          d.copy = q.copy | q.buf_r[P_COPY];
          d.perm = q.perm | q.buf_r[P_PERM];
          // RULE11: freely rewritable cells
          d.temp = q.buf_r[P_TEMP];
          d.crc = q.buf_r[P_CRC +: 7];
        end
        d.buf_r = {5'h00, otp_bad, ro_bad, q.sel, 120'h0};
        d.cnt = LEN_STATUS;
        d.gap = '0;
        d.st = D_GAP;
      end
      D_GAP: begin
        if (rise) begin
          d.gap = q.gap + 2'h1;
          if (q.gap == RESP_GAP - 2'h1) begin
            d.st = D_TXS;
          end
        end
      end
      D_TXS: begin
        if (rise) begin
          d.cmd_oe = 1'b1;
          d.cmd_o = 1'b0;
          d.st = D_TXB;
        end
      end
      D_TXB: begin
        if (rise) begin
          d.cmd_o = q.buf_r[127];
          d.buf_r = {q.buf_r[126:0], 1'b0};
          d.cnt = q.cnt - 8'h01;
          if (q.cnt == 8'h01) begin
            d.st = D_TXE;
          end
        end
      end
      D_TXE: begin
        if (rise) begin
          d.cmd_o = 1'b1;
          d.st = D_REL;
        end
      end
      D_REL: begin
        if (rise) begin
          d.cmd_oe = 1'b0;
          d.st = D_IDLE;
        end
      end
      default: d.st = D_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    // RULE13: address cleared at power-up
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.cmd_d_o = q.cmd_o;
  assign lnk.cmd_d_oe = q.cmd_oe;
  assign ready = q.rdy;
  assign selected = q.sel;
  assign card_address = q.addr;
  assign copy_flag = q.copy;
  assign perm_protect = q.perm;
  assign temp_protect = q.temp;

endmodule // cdr_card

// *** src/cdr_host.sv ***
// Host end: makes the link clock, sends the preamble and commands, collects answers.
// Assumes one card on the link and a pulled-up command line.
`timescale 1ns/1ns
module cdr_host #(
  parameter bit SPI_MODE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  cdr_link_if.host lnk,
  // Requests
  input wire logic req_valid,
  input wire logic [5:0] req_idx,
  input wire logic [31:0] req_arg,
  input wire logic [127:0] req_data,
  output logic req_ready,
  // Answers
  output logic resp_valid,
  output logic resp_timeout,
  output logic [127:0] resp_data,
  // Card facts
  output logic init_done,
  output logic [15:0] card_address,
  output logic single_erase_ok
);
  import cdr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {H_PRE, H_IDLE, H_TX, H_REL, H_WAIT, H_RX, H_DONE} cdr_hst_t;

  typedef struct packed {
    cdr_hst_t st;
    logic [7:0] div;
    logic lclk;
    logic cm_m;
    logic cm_s;
    logic [7:0] cnt;
    logic [7:0] len;
    logic [5:0] idx;
    logic [177:0] tx;
    logic [127:0] rx;
    logic cmd_o;
    logic cmd_oe;
    logic cs;
    logic rdy;
    logic rv;
    logic rto;
    logic init;
    logic [15:0] addr;
    logic erase_ok;
  } cdr_hstate_t;

  cdr_hstate_t q, d;
  logic rise;
  logic fall;
  logic [31:0] arg;

  always_comb begin
    d = q;
    d.rv = 1'b0;
    d.cm_m = lnk.cmd_line;
    d.cm_s = q.cm_m;
    // Link clock divider
    rise = 1'b0;
    fall = 1'b0;
    if (q.div == 8'(LINK_HALF_CYC - 1)) begin
      d.div = '0;
      d.lclk = ~q.lclk;
      rise = ~q.lclk;
      fall = q.lclk;
    end else begin
      d.div = q.div + 8'h01;
    end
    // RULE14: addressed read uses the published address
    arg = (req_idx == CMD_SEND_SPECIFICS) ? {q.addr, req_arg[15:0]} : req_arg;
    unique case (q.st)
      H_PRE: begin
        // RULE16: line held high for the preamble
        d.cmd_oe = 1'b1;
        d.cmd_o = 1'b1;
        // RULE17: chip select high throughout the preamble
        d.cs = 1'b1;
        if (rise) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == PRE_CLOCKS) begin
            d.st = H_IDLE;
            d.init = 1'b1;
            d.rdy = 1'b1;
            d.cmd_oe = 1'b0;
            d.cs = ~SPI_MODE;
          end
        end
      end
      H_IDLE: begin
        if (req_valid) begin
          d.rdy = 1'b0;
          d.idx = req_idx;
          // Frame, then idle 1 and start 0 ahead of the data; the pull-up supplies the data end bit
          d.tx = {2'h1, req_idx, arg, 7'h00, 1'b1, 2'h2, req_data};
          d.cnt = (req_idx == CMD_PROGRAM_SPECIFICS) ? FRAME_BITS + DATA_BITS + 8'h02 : FRAME_BITS;
          unique case (req_idx)
            CMD_PUBLISH_ADDR: d.len = LEN_ADDR;
            CMD_SEND_SPECIFICS: d.len = LEN_SPECIFICS;
            default: d.len = LEN_STATUS;
          endcase
          d.st = H_TX;
        end
      end
      H_TX: begin
        if (fall) begin
          d.cmd_oe = 1'b1;
          d.cmd_o = q.tx[177];
          d.tx = {q.tx[176:0], 1'b1};
          d.cnt = q.cnt - 8'h01;
          if (q.cnt == 8'h01) begin
            d.st = H_REL;
          end
        end
      end
      H_REL: begin
        if (fall) begin
          d.cmd_oe = 1'b0;
          d.cnt = '0;
          d.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (rise) begin
          d.cnt = q.cnt + 8'h01;
          if (!q.cm_s) begin
            d.cnt = q.len;
            d.rx = '0;
            d.st = H_RX;
          end else if (q.cnt == RESP_TIMEOUT) begin
            d.rv = 1'b1;
            d.rto = 1'b1;
            d.cnt = '0;
            d.st = H_DONE;
          end
        end
      end
      H_RX: begin
        if (rise) begin
          d.rx = {q.rx[126:0], q.cm_s};
          d.cnt = q.cnt - 8'h01;
          if (q.cnt == 8'h01) begin
            d.rv = 1'b1;
            d.rto = 1'b0;
            if (q.idx == CMD_PUBLISH_ADDR) begin
              d.addr = {q.rx[14:0], q.cm_s};
            end
            // RULE12: remember whether single erase is allowed
            if (q.idx == CMD_SEND_SPECIFICS) begin
              d.erase_ok = q.rx[P_ERASE_SINGLE - 1];
            end
            d.st = H_DONE;
          end
        end
      end
      H_DONE: begin
        // Let the card finish its end bit and release the line
        if (rise) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == 8'h02) begin
            d.rdy = 1'b1;
            d.st = H_IDLE;
          end
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.lclk = q.lclk;
  assign lnk.cs_hi = q.cs;
  assign lnk.cmd_h_o = q.cmd_o;
  assign lnk.cmd_h_oe = q.cmd_oe;
  assign req_ready = q.rdy;
  assign resp_valid = q.rv;
  assign resp_timeout = q.rto;
  assign resp_data = q.rx;
  assign init_done = q.init;
  assign card_address = q.addr;
  assign single_erase_ok = q.erase_ok;

endmodule // cdr_host

// *** src/cdr_link_if.sv ***
// Link between the host controller and the card register end.
// Assumes an external pull-up: an undriven command line reads high.
`timescale 1ns/1ns
interface cdr_link_if;
  logic lclk;
  logic cs_hi;
  logic cmd_h_o;
  logic cmd_h_oe;
  logic cmd_d_o;
  logic cmd_d_oe;
  logic cmd_line;

  // Open-drain style resolution with pull-up
  assign cmd_line = (cmd_h_oe ? cmd_h_o : 1'b1) & (cmd_d_oe ? cmd_d_o : 1'b1);

  modport host (output lclk, output cs_hi, output cmd_h_o, output cmd_h_oe, input cmd_line);
  modport dev (input lclk, input cs_hi, input cmd_line, output cmd_d_o, output cmd_d_oe);
endinterface

// *** src/cdr_pkg.sv ***
// Constants shared by both ends of the card data register link.
// Assumes a 100 MHz system clock on both ends.
package cdr_pkg;

  // ****************************************
  // Link timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] PRE_CLOCKS = 8'h4A;
  localparam logic [1:0] RESP_GAP = 2'h2;
  localparam logic [7:0] RESP_TIMEOUT = 8'h40;

  // ****************************************
  // Frames and commands
  // ****************************************
  localparam logic [7:0] FRAME_BITS = 8'h30;
  localparam logic [7:0] DATA_BITS = 8'h80;
  localparam logic [5:0] CMD_PUBLISH_ADDR = 6'h03;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_SEND_SPECIFICS = 6'h09;
  localparam logic [5:0] CMD_PROGRAM_SPECIFICS = 6'h1B;
  localparam logic [7:0] LEN_ADDR = 8'h10;
  localparam logic [7:0] LEN_STATUS = 8'h08;
  localparam logic [7:0] LEN_SPECIFICS = 8'h80;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ****************************************
  // Card-specific data field layout
  // ****************************************
  localparam int P_VERSION = 126;
  localparam int P_ACCESS_TIME = 112;
  localparam int P_ACCESS_CLOCKS = 104;
  localparam int P_RATE = 96;
  localparam int P_CLASSES = 84;
  localparam int P_RD_LEN = 80;
  localparam int P_RD_PARTIAL = 79;
  localparam int P_WR_MISALIGN = 78;
  localparam int P_RD_MISALIGN = 77;
  localparam int P_DRIVER_STAGE = 76;
  localparam int P_SIZE = 48;
  localparam int P_ERASE_SINGLE = 46;
  localparam int P_SECTOR = 39;
  localparam int P_GRP_SIZE = 32;
  localparam int P_GRP_EN = 31;
  localparam int P_SPEED_FACTOR = 26;
  localparam int P_WR_LEN = 22;
  localparam int P_WR_PARTIAL = 21;
  localparam int P_COPY = 14;
  localparam int P_PERM = 13;
  localparam int P_TEMP = 12;
  localparam int P_CRC = 1;
  localparam logic [1:0] V_VERSION = 2'h1;
  localparam logic [7:0] V_ACCESS_TIME = 8'h0E;
  localparam logic [7:0] V_ACCESS_CLOCKS = 8'h00;
  localparam logic [7:0] V_RATE_LOW = 8'h32;
  localparam logic [7:0] V_RATE_HIGH = 8'h5A;
  localparam logic [1:0] V_CLASSES_HI = 2'h1;
  localparam logic [8:0] V_CLASSES_LO = 9'h1B5;
  localparam logic [3:0] V_BLOCK_LEN = 4'h9;
  localparam logic [6:0] V_SECTOR = 7'h7F;
  localparam logic [6:0] V_GRP_SIZE = 7'h00;
  localparam logic [2:0] V_SPEED_FACTOR = 3'h2;
  localparam logic [127:0] WRITABLE_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_70FE;

endpackage
